// [pmw_pkg.sv]
// Constants and types for the power mode and wakeup controller.
package pmw_pkg;
   // Clock rate and timing.
   localparam int CLK_HZ          = 40_000_000;
   localparam int SLEEP_RESUME_US = 15;
   localparam int HIB_RESUME_US   = 100;
   localparam int SLEEP_RESUME_CYC = (SLEEP_RESUME_US * (CLK_HZ / 1_000_000));
   // The pin synchroniser, edge detect, state change and output register use four cycles.
   // The hibernate count gives them back, so the whole return stays inside the budget.
   localparam int WAKE_LAT_CYC     = 4;
   localparam int HIB_RESUME_CYC   = (HIB_RESUME_US * (CLK_HZ / 1_000_000)) - 1 - WAKE_LAT_CYC;
   localparam int RESUME_W         = 12;

   // Subsystem template layout.
   localparam int NSUB        = 8;
   localparam int SUB_CPU     = 0;
   localparam int SUB_FLASH   = 1;
   localparam logic [NSUB-1:0] ACT_TMPL_RST = 8'hFF;
   localparam logic [NSUB-1:0] ALT_TMPL_RST = 8'hFC;

   // Wakeup source bit positions.
   localparam int NWAKE      = 8;
   localparam int WK_CMP     = 0;
   localparam int WK_PRG     = 1;
   localparam int WK_SUPV    = 2;
   localparam int WK_TWHEEL  = 3;
   localparam int WK_PIN     = 4;
   localparam int WK_XRST    = 5;
   localparam int WK_WDOG    = 6;
   localparam int WK_PRST    = 7;
   localparam logic [NWAKE-1:0] WAKE_EN_RST = 8'hE0;

   // Interrupt status bits.
   localparam int NIRQ      = 3;
   localparam int IRQ_WAKE  = 0;
   localparam int IRQ_TICK  = 1;
   localparam int IRQ_READY = 2;

   // Register byte offsets.
   localparam logic [7:0] OFS_MODE     = 8'h00;
   localparam logic [7:0] OFS_ACT_TMPL = 8'h04;
   localparam logic [7:0] OFS_ALT_TMPL = 8'h08;
   localparam logic [7:0] OFS_WAKE_EN  = 8'h0C;
   localparam logic [7:0] OFS_TW_PER   = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h1C;
   localparam logic [7:0] OFS_STATUS   = 8'h20;

   localparam int TW_W = 16;
   localparam logic [TW_W-1:0] TW_PER_RST = 16'h0000;

   // Mode encodings as seen by software.
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_ALT    = 2'h1;
   localparam logic [1:0] MODE_SLEEP  = 2'h2;
   localparam logic [1:0] MODE_HIB    = 2'h3;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_ALT,
      ST_SLEEP,
      ST_HIB,
      ST_RESUME
   } pmw_state_t;
endpackage

// [pmw_ctrl.sv]
// Power mode and wakeup controller with an APB register slave.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - A cleared template bit gates that subsystem's clock enable.
// - Firmware may change template bits anytime; changes apply next cycle.
// - CPU may clear its own bit; the next wakeup sets it again.
// - Any wakeup forces active mode and the CPU bit on.
// - Reset leaves the controller in active mode.
// - Alternate active mode uses its own reduced template.
// - Leaving sleep waits 15 us before entering active mode.
// - Hibernate gates nearly everything but keeps configuration and memory retained.
// - Hibernate holds digital output levels and keeps pin interrupt setup.
// - Hibernate is left only by the pin interrupt source.
// - Hibernate resume to active completes in under 100 us.
// - Wakeup sources are enabled per source, interrupts or resets.
// - Interrupt sources: comparator, programmable block, supervisor, timewheel, pin.
// - The timewheel raises periodic ticks that can wake the system.
// - Reset sources: external reset pin, watchdog timeout, precision reset monitor.
module pmw_ctrl
   import pmw_pkg::*;
(
   // Clock and reset.
   input  wire logic             REF_CLK,
   input  wire logic             RST_N,
   // APB slave.
   input  wire logic             PSEL,
   input  wire logic             PENABLE,
   input  wire logic             PWRITE,
   input  wire logic [7:0]       PADDR,
   input  wire logic [31:0]      PWDATA,
   output logic      [31:0]      PRDATA,
   output logic                  PREADY,
   output logic                  PSLVERR,
   // Wakeup sources, asynchronous levels.
   input  wire logic             CMP_IRQ,
   input  wire logic             PRG_IRQ,
   input  wire logic             SUPV_IRQ,
   input  wire logic             PIN_IRQ,
   input  wire logic             EXTERNAL_RESET_PIN,
   input  wire logic             WATCHDOG_TIMEOUT,
   input  wire logic             PRECISION_RESET_MONITOR,
   // Power control outputs.
   output logic      [NSUB-1:0]  SUBSYS_CLK_EN,
   output logic      [1:0]       POWER_MODE,
   output logic                  PIN_HOLD,
   output logic                  RETAIN,
   output logic                  REG_LOW,
   output logic                  IRQ
);

   // Synchronisers for the asynchronous sources.
   logic [NWAKE-1:0] src_raw;
   logic [NWAKE-1:0] sync1_q;
   logic [NWAKE-1:0] sync2_q;
   logic [NWAKE-1:0] prev_q;
   logic [NWAKE-1:0] edge_ev;
   logic [NWAKE-1:0] wake_hit;

   // Registers.
   pmw_state_t        state_q;
   logic [NSUB-1:0]   act_tmpl_q;
   logic [NSUB-1:0]   alt_tmpl_q;
   logic [NWAKE-1:0]  wake_en_q;
   logic [TW_W-1:0]   tw_per_q;
   logic [TW_W-1:0]   tw_cnt_q;
   logic              tw_tick;
   logic [NIRQ-1:0]   irq_stat_q;
   logic [NIRQ-1:0]   irq_en_q;
   logic [RESUME_W-1:0] resume_q;
   logic [NWAKE-1:0]  last_src_q;

   logic              wr_en;
   logic              rd_phase;
   logic              addr_ok;
   logic              wake_any;
   logic              resume_done;
   logic [NIRQ-1:0]   irq_set;
   logic [31:0]       rdata;

   assign src_raw[WK_CMP]    = CMP_IRQ;
   assign src_raw[WK_PRG]    = PRG_IRQ;
   assign src_raw[WK_SUPV]   = SUPV_IRQ;
   assign src_raw[WK_TWHEEL] = 1'b0;
   assign src_raw[WK_PIN]    = PIN_IRQ;
   assign src_raw[WK_XRST]   = EXTERNAL_RESET_PIN;
   assign src_raw[WK_WDOG]   = WATCHDOG_TIMEOUT;
   assign src_raw[WK_PRST]   = PRECISION_RESET_MONITOR;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= src_raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // Rising edges are events; the timewheel tick joins as an internal source.
   always_comb begin
      edge_ev = sync2_q & ~prev_q;
      edge_ev[WK_TWHEEL] = tw_tick;
   end

   // Per-source enables; in hibernate only the pin source counts.
   always_comb begin
      wake_hit = edge_ev & wake_en_q;
      if (state_q == ST_HIB) begin
         wake_hit = '0;
         wake_hit[WK_PIN] = edge_ev[WK_PIN] & wake_en_q[WK_PIN];
      end
   end
   assign wake_any = |wake_hit;

   // Central timewheel; a period of zero stops it.
   assign tw_tick = (tw_per_q != '0) && (tw_cnt_q == tw_per_q);
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tw_cnt_q <= '0;
      end else if (tw_tick || tw_per_q == '0) begin
         tw_cnt_q <= '0;
      end else begin
         tw_cnt_q <= tw_cnt_q + 1'b1;
      end
   end

   // APB decode: one wait state, the write lands on the completing edge.
   assign rd_phase = PSEL && PENABLE && !PREADY;
   assign wr_en    = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   always_comb begin
      unique case (PADDR)
         OFS_MODE, OFS_ACT_TMPL, OFS_ALT_TMPL, OFS_WAKE_EN, OFS_TW_PER,
         OFS_IRQ_STAT, OFS_IRQ_CLR, OFS_IRQ_EN, OFS_STATUS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   always_comb begin
      rdata = '0;
      unique case (PADDR)
         OFS_MODE:     rdata[1:0] = POWER_MODE;
         OFS_ACT_TMPL: rdata[NSUB-1:0] = act_tmpl_q;
         OFS_ALT_TMPL: rdata[NSUB-1:0] = alt_tmpl_q;
         OFS_WAKE_EN:  rdata[NWAKE-1:0] = wake_en_q;
         OFS_TW_PER:   rdata[TW_W-1:0] = tw_per_q;
         OFS_IRQ_STAT: rdata[NIRQ-1:0] = irq_stat_q;
         OFS_IRQ_EN:   rdata[NIRQ-1:0] = irq_en_q;
         OFS_STATUS:   rdata = {8'h00, last_src_q, SUBSYS_CLK_EN, 5'h00, state_q};
         default:      rdata = '0;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= '0;
      end else begin
         PREADY  <= rd_phase;
         PSLVERR <= rd_phase && !addr_ok;
         if (rd_phase && !PWRITE) begin
            PRDATA <= rdata;
         end
      end
   end

   // Active template; a wakeup sets the CPU bit and beats a same-cycle write.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         act_tmpl_q <= ACT_TMPL_RST;
      end else begin
         if (wr_en && PADDR == OFS_ACT_TMPL) begin
            act_tmpl_q <= PWDATA[NSUB-1:0];
         end
         if (wake_any) begin
            act_tmpl_q[SUB_CPU] <= 1'b1;
         end
      end
   end

   // Configuration registers survive hibernate because nothing clears them there.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         alt_tmpl_q <= ALT_TMPL_RST;
         wake_en_q  <= WAKE_EN_RST;
         tw_per_q   <= TW_PER_RST;
         irq_en_q   <= '0;
      end else if (wr_en) begin
         unique case (PADDR)
            OFS_ALT_TMPL: alt_tmpl_q <= PWDATA[NSUB-1:0];
            OFS_WAKE_EN:  wake_en_q  <= PWDATA[NWAKE-1:0];
            OFS_TW_PER:   tw_per_q   <= PWDATA[TW_W-1:0];
            OFS_IRQ_EN:   irq_en_q   <= PWDATA[NIRQ-1:0];
            default:      ;
         endcase
      end
   end

   // Mode machine.
   assign resume_done = (resume_q == '0);
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q  <= ST_ACTIVE;
         resume_q <= '0;
      end else begin
         unique case (state_q)
            ST_ACTIVE, ST_ALT: begin
               if (wake_any) begin
                  state_q <= ST_ACTIVE;
               end else if (wr_en && PADDR == OFS_MODE) begin
                  unique case (PWDATA[1:0])
                     MODE_ACTIVE: state_q <= ST_ACTIVE;
                     MODE_ALT:    state_q <= ST_ALT;
                     MODE_SLEEP:  state_q <= ST_SLEEP;
                     MODE_HIB:    state_q <= ST_HIB;
                  endcase
               end
            end
            ST_SLEEP: begin
               if (wake_any) begin
                  state_q  <= ST_RESUME;
                  resume_q <= RESUME_W'(SLEEP_RESUME_CYC - 1);
               end
            end
            ST_HIB: begin
               if (wake_any) begin
                  state_q  <= ST_RESUME;
                  resume_q <= RESUME_W'(HIB_RESUME_CYC - 1);
               end
            end
            ST_RESUME: begin
               if (resume_done) begin
                  state_q <= ST_ACTIVE;
               end else begin
                  resume_q <= resume_q - 1'b1;
               end
            end
         endcase
      end
   end

   // Clock gating and power outputs, all registered.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         SUBSYS_CLK_EN <= ACT_TMPL_RST;
         POWER_MODE    <= MODE_ACTIVE;
         PIN_HOLD      <= 1'b0;
         RETAIN        <= 1'b0;
         REG_LOW       <= 1'b0;
      end else begin
         unique case (state_q)
            ST_ACTIVE: begin
               SUBSYS_CLK_EN <= act_tmpl_q;
               POWER_MODE    <= MODE_ACTIVE;
            end
            ST_ALT: begin
               SUBSYS_CLK_EN <= alt_tmpl_q;
               POWER_MODE    <= MODE_ALT;
            end
            ST_SLEEP: begin
               SUBSYS_CLK_EN <= '0;
               POWER_MODE    <= MODE_SLEEP;
            end
            ST_HIB: begin
               SUBSYS_CLK_EN <= '0;
               POWER_MODE    <= MODE_HIB;
            end
            ST_RESUME: begin
               SUBSYS_CLK_EN <= '0;
               POWER_MODE    <= POWER_MODE;
            end
         endcase
         PIN_HOLD <= (state_q == ST_HIB);
         RETAIN   <= (state_q == ST_HIB);
         REG_LOW  <= (state_q == ST_HIB) || (state_q == ST_SLEEP);
      end
   end

   // Sticky interrupts; a new event beats a same-cycle clear.
   assign irq_set[IRQ_WAKE]  = wake_any;
   assign irq_set[IRQ_TICK]  = tw_tick;
   assign irq_set[IRQ_READY] = (state_q == ST_RESUME) && resume_done;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_stat_q <= '0;
         last_src_q <= '0;
         IRQ        <= 1'b0;
      end else begin
         if (wr_en && PADDR == OFS_IRQ_CLR) begin
            irq_stat_q <= (irq_stat_q & ~PWDATA[NIRQ-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         if (wake_any) begin
            last_src_q <= wake_hit;
         end
         IRQ <= |(irq_stat_q & irq_en_q);
      end
   end

endmodule // pmw_ctrl
`default_nettype wire

// [pmw_ctrl_props.sv]
// Assertion checker for the power mode and wakeup controller ports.
`timescale 1ns/1ps
`default_nettype none
module pmw_props
   import pmw_pkg::*;
(
   // Clock, reset and bus.
   input wire logic            REF_CLK,
   input wire logic            RST_N,
   input wire logic            PSEL,
   input wire logic            PENABLE,
   input wire logic [7:0]      PADDR,
   input wire logic            PREADY,
   input wire logic            PSLVERR,
   // Power control.
   input wire logic [NSUB-1:0] SUBSYS_CLK_EN,
   input wire logic [1:0]      POWER_MODE,
   input wire logic            PIN_HOLD,
   input wire logic            RETAIN,
   input wire logic            REG_LOW
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_first_access;
      PSEL && PENABLE && !PREADY && !$past(PENABLE);
   endsequence
   // A return from a gated mode is seen by all clocks having been off just before.
   sequence s_wake_done;
      POWER_MODE == MODE_ACTIVE && $past(POWER_MODE) != MODE_ACTIVE && $past(SUBSYS_CLK_EN) == '0;
   endsequence
   a_apb_one_wait: assert property (s_first_access |=> PREADY) else $error("ready late");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
   a_err_unmapped: assert property (PREADY && PADDR > OFS_STATUS |-> PSLVERR) else $error("no err");
   a_boot_active: assert property ($rose(RST_N) |-> POWER_MODE == MODE_ACTIVE && SUBSYS_CLK_EN == ACT_TMPL_RST) else $error("boot");
   a_hold_in_hib: assert property (PIN_HOLD |-> POWER_MODE == MODE_HIB) else $error("hold");
   a_retain_hib: assert property (RETAIN == PIN_HOLD) else $error("retain");
   a_hib_gated: assert property (PIN_HOLD |-> SUBSYS_CLK_EN == '0) else $error("hib clk");
   a_low_gated: assert property (REG_LOW |-> SUBSYS_CLK_EN == '0) else $error("low clk");
   a_wake_cpu_on: assert property (s_wake_done |-> SUBSYS_CLK_EN[SUB_CPU]) else $error("cpu off");
endmodule // pmw_props
bind pmw_ctrl pmw_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .SUBSYS_CLK_EN(SUBSYS_CLK_EN), .POWER_MODE(POWER_MODE), .PIN_HOLD(PIN_HOLD),
   .RETAIN(RETAIN), .REG_LOW(REG_LOW));
`default_nettype wire

// [pmw_wake_src.sv]
// Model of the wakeup sources outside the controller.
`timescale 1ns/1ps
`default_nettype none
module pmw_wake_src
   import pmw_pkg::*;
(
   // Clock and request.
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             go,
   input  wire logic [2:0]       sel,
   // Source levels.
   output logic      [NWAKE-1:0] wk
);
   // A line holds its level until the next request, so nothing toggles fast.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wk <= '0;
      end else if (go) begin
         wk <= NWAKE'(1) << sel;
      end
   end
endmodule // pmw_wake_src
`default_nettype wire

// [pmw_ctrl_tb.sv]
// Self-checking testbench for the power mode and wakeup controller.
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl_tb
   import pmw_pkg::*;
;
   logic             clk, rst_n, psel, pen, pwr, go, pready, pslverr, hold, retain, reglow, irq;
   logic [7:0]       paddr, clk_en, t;
   logic [31:0]      pwdata, prdata;
   logic [1:0]       pmode;
   logic [2:0]       sel;
   logic [NWAKE-1:0] wk;
   logic [32:0]      exp_q[$];
   int               fail_count = 0;
   int               compares = 0;
   int               n;
   pmw_wake_src u_src (.clk(clk), .rst_n(rst_n), .go(go), .sel(sel), .wk(wk));
   pmw_ctrl uut (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CMP_IRQ(wk[WK_CMP]), .PRG_IRQ(wk[WK_PRG]), .SUPV_IRQ(wk[WK_SUPV]), .PIN_IRQ(wk[WK_PIN]),
      .EXTERNAL_RESET_PIN(wk[WK_XRST]), .WATCHDOG_TIMEOUT(wk[WK_WDOG]),
      .PRECISION_RESET_MONITOR(wk[WK_PRST]), .SUBSYS_CLK_EN(clk_en), .POWER_MODE(pmode),
      .PIN_HOLD(hold), .RETAIN(retain), .REG_LOW(reglow), .IRQ(irq));
   task automatic report_and_stop();
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) pen <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      cmp(33'(pready), 33'h1);
      psel <= 1'b0;
      pen <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic mode(input logic [1:0] m);
      apb(1'b1, OFS_MODE, 32'(m));
      @(posedge clk);
   endtask
   // The source is released afterwards so that the next use gives a fresh edge.
   task automatic wake(input logic [2:0] s, input int lo, input int hi);
      go <= 1'b1;
      sel <= s;
      @(posedge clk) go <= 1'b0;
      n = 1;
      while (pmode !== MODE_ACTIVE && n < hi + 9) begin
         @(posedge clk);
         n++;
      end
      cmp(33'(n >= lo && n <= hi), 33'h1);
      go <= 1'b1;
      sel <= 3'h3;
      @(posedge clk) go <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) if (psel && pen && pready === 1'b1 && !pwr) cmp({pslverr, prdata}, exp_q.pop_front());
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #750000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      {rst_n, psel, pen, pwr, go, paddr, pwdata} = '0;
      sel = 3'h3;
      void'($urandom(97789));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      cmp(33'({pmode, clk_en}), 33'(ACT_TMPL_RST));
      rd(OFS_MODE, 33'h0);
      rd(OFS_ACT_TMPL, 33'(ACT_TMPL_RST));
      rd(OFS_ALT_TMPL, 33'(ALT_TMPL_RST));
      rd(OFS_WAKE_EN, 33'(WAKE_EN_RST));
      rd(OFS_TW_PER, 33'h0);
      rd(OFS_STATUS, 33'h0000FF00);
      rd(8'h24, 33'h100000000);
      repeat (4) begin
         t = 8'($urandom()) & 8'hFE;
         apb(1'b1, OFS_ACT_TMPL, 32'(t));
         cmp(33'(clk_en), 33'(t));
      end
      apb(1'b1, OFS_WAKE_EN, 32'h000000F7);
      mode(MODE_ALT);
      cmp(33'({pmode, clk_en}), {23'h0, MODE_ALT, ALT_TMPL_RST});
      mode(MODE_ACTIVE);
      cmp(33'({pmode, clk_en}), 33'(t));
      mode(MODE_ALT);
      wake(3'(WK_CMP), 1, 8);
      cmp(33'(clk_en), 33'(t | 8'h01));
      apb(1'b1, OFS_IRQ_CLR, 32'h7);
      apb(1'b1, OFS_IRQ_EN, 32'h1);
      for (int i = 0; i < NWAKE; i++) if (i != WK_TWHEEL) begin
         mode(MODE_SLEEP);
         cmp(33'({reglow, clk_en}), 33'h100);
         wake(3'(i), 600, 612);
         cmp(33'(clk_en), 33'(t | 8'h01));
      end
      cmp(33'(irq), 33'h1);
      rd(OFS_IRQ_STAT, 33'h5);
      apb(1'b1, OFS_IRQ_EN, 32'h0);
      cmp(33'(irq), 33'h0);
      apb(1'b1, OFS_IRQ_CLR, 32'h7);
      rd(OFS_IRQ_STAT, 33'h0);
      apb(1'b1, OFS_ACT_TMPL, 32'h5A);
      mode(MODE_HIB);
      cmp(33'({hold, retain, reglow, clk_en}), 33'h700);
      go <= 1'b1;
      sel <= 3'(WK_CMP);
      @(posedge clk) go <= 1'b0;
      repeat (4000) @(posedge clk);
      cmp(33'(pmode), 33'(MODE_HIB));
      wake(3'(WK_PIN), 3995, HIB_RESUME_US * (CLK_HZ / 1_000_000) + 1);
      rd(OFS_ACT_TMPL, 33'h5B);
      cmp(33'(clk_en), 33'h5B);
      apb(1'b1, OFS_TW_PER, 32'h63);
      apb(1'b1, OFS_WAKE_EN, 32'h8);
      mode(MODE_SLEEP);
      wake(3'(WK_TWHEEL), 600, 715);
      rd(OFS_IRQ_STAT, 33'h7);
      report_and_stop();
   end
endmodule // pmw_ctrl_tb
`default_nettype wire
